// ===== src/sac_map.svh
// Purpose: register map, field positions and timing counts of the converter control block
// Assumes: apb byte addresses are four times the printed register index
// Notes: definitions only
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_IDX_IRQ_EN      8'h0b
`define SAC_IDX_IRQ_PEND    8'h0c
`define SAC_IDX_RES_HI      8'h17
`define SAC_IDX_CTRL        8'h18
`define SAC_IDX_REFCH       8'h19
`define SAC_IDX_IRQ_STAT    8'h1a
`define SAC_IDX_IRQ_MASK    8'h1b
`define SAC_DONE_BIT        7
`define SAC_DONE_CLR_VAL    8'h7f
`define SAC_START_BIT       3
`define SAC_REFCH_RST       8'h1f
`define SAC_CHAN_EXT_MAX    5'h0c
`define SAC_CHAN_BANDGAP    5'h0e
`define SAC_CHAN_QVCC       5'h17
`define SAC_REF_RESERVED    2'h2
`define SAC_BIT_DECISIONS   4'hc
`define SAC_DIV_MAX_LOG     4'h8
`endif

// ===== src/sac_pkg.sv
// Purpose: types shared by the converter control block
// Assumes: nothing beyond the map header
// Notes: sequencer states
package sac_pkg;
   typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_DECIDE, SAC_FINISH} sac_state_t;
endpackage

// ===== src/sac_top.sv
// Purpose: control of a 12-bit successive approximation converter behind an apb slave
// Assumes: analog comparator answers within one converter clock; inputs synchronous to clk_i
// Notes: byte registers sit in the low bits of one word each; zero wait states
`timescale 1ns/100ps
`include "sac_map.svh"
//
// Contract
// - 12-bit result built by successive approximation, fifteen inputs via channel field
// - converter clock is system clock divided by 256 down to 2 per divider field
// - writing start launches conversion; hardware clears start at the end
// - start reads 1 while converting, 0 when complete
// - channel codes 0..12 external, 0x0e bandgap, 0x17 quarter supply, rest reserved
// - reference field picks supply/1.2V, 2.48V bandgap, reserved, 2.00V bandgap
// - with reference field 00, low reference bit picks supply or 1.2V bandgap
// - result bits 11..4 in high byte, bits 3..0 in control upper nibble
// - done flag set at conversion end, cleared by writing 0x7f to pending register
module sac_top
   import sac_pkg::*;
#(
   parameter int RES_BITS = 12
)
(
   input wire logic clk_i,                 // system clock, 50 MHz
   input wire logic sys_rst_i,             // async reset, active high
   input wire logic psel_i,                // apb select
   input wire logic penable_i,             // apb enable
   input wire logic pwrite_i,              // apb direction
   input wire logic [11:0] paddr_i,        // apb byte address
   input wire logic [31:0] pwdata_i,       // apb write data
   output logic [31:0] prdata_o,           // apb read data
   output logic pready_o,                  // apb ready
   output logic pslverr_o,                 // apb error on unmapped address
   input wire logic cmp_i,                 // comparator: input at or above trial level
   output logic [RES_BITS-1:0] dac_o,      // trial code to the capacitor array
   output logic sample_o,                  // sample switch closed
   output logic [4:0] mux_sel_o,           // input multiplexer select
   output logic mux_valid_o,               // channel code is not reserved
   output logic [1:0] ref_sel_o,           // reference source select
   output logic ref_low_o,                 // low reference select
   output logic irq_o                      // level interrupt
);
   import sac_pkg::*;

   sac_state_t state_r;
   logic [7:0] irq_en_r;
   logic done_flag_r;
   logic [7:0] stat_r;
   logic [7:0] mask_r;
   logic [2:0] div_sel_r;
   logic start_busy_r;
   logic [7:0] refch_r;
   logic [RES_BITS-1:0] result_r;
   logic [RES_BITS-1:0] sar_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] div_cnt_r;
   logic tick;
   logic [7:0] div_last;
   logic acc;
   logic wr;
   logic [9:0] idx;
   logic mapped;
   logic start_req;
   logic done_evt;
   logic [7:0] rd_byte;
   logic [RES_BITS-1:0] trial_bit;
   logic wr_ctrl;
   logic wr_refch;
   logic wr_irq_en;
   logic wr_pend;
   logic wr_stat;
   logic wr_mask;

   // word index matches one byte register
   function automatic logic idx_hit(input logic [9:0] i, input logic [7:0] reg_idx);
      idx_hit = i == {2'h0, reg_idx};
   endfunction

   function automatic logic chan_ok(input logic [4:0] c);
      chan_ok = (c <= `SAC_CHAN_EXT_MAX) || (c == `SAC_CHAN_BANDGAP) || (c == `SAC_CHAN_QVCC);
   endfunction

   assign acc = psel_i & penable_i;
   assign wr = acc & pwrite_i;
   assign idx = paddr_i[11:2];
   assign mapped = (idx == {2'h0, `SAC_IDX_IRQ_EN}) || (idx == {2'h0, `SAC_IDX_IRQ_PEND})
      || (idx == {2'h0, `SAC_IDX_RES_HI}) || (idx == {2'h0, `SAC_IDX_CTRL})
      || (idx == {2'h0, `SAC_IDX_REFCH}) || (idx == {2'h0, `SAC_IDX_IRQ_STAT})
      || (idx == {2'h0, `SAC_IDX_IRQ_MASK});
   // one write strobe per writable register, taken in the access cycle
   assign wr_ctrl = wr && idx_hit(idx, `SAC_IDX_CTRL);
   assign wr_refch = wr && idx_hit(idx, `SAC_IDX_REFCH);
   assign wr_irq_en = wr && idx_hit(idx, `SAC_IDX_IRQ_EN);
   assign wr_pend = wr && idx_hit(idx, `SAC_IDX_IRQ_PEND);
   assign wr_stat = wr && idx_hit(idx, `SAC_IDX_IRQ_STAT);
   assign wr_mask = wr && idx_hit(idx, `SAC_IDX_IRQ_MASK);

   // a start written while busy is dropped by the sequencer; the end beats a start
   assign start_req = wr_ctrl && pwdata_i[`SAC_START_BIT];
   assign done_evt = tick && state_r == SAC_FINISH;

   // divider: terminal count is 2^(8-sel) - 1
   assign div_last = 8'(({1'b0, 8'hff} >> div_sel_r));

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         div_cnt_r <= 8'h00;
      else if (state_r == SAC_IDLE || div_cnt_r == div_last)
         div_cnt_r <= 8'h00;
      else
         div_cnt_r <= div_cnt_r + 8'h01;
   end
   assign tick = (state_r != SAC_IDLE) && div_cnt_r == div_last;

   // one-hot trial position, msb first; shifted once more it marks the next trial
   assign trial_bit = {1'b1, {(RES_BITS-1){1'b0}}} >> bit_cnt_r;

   // sequencer: sample, twelve decisions, finish
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_r <= SAC_IDLE;
         sar_r <= '0;
         bit_cnt_r <= 4'h0;
      end
      else
      begin
         unique case (state_r)
            SAC_IDLE:
               if (start_req)
               begin
                  state_r <= SAC_SAMPLE;
                  sar_r <= {1'b1, {(RES_BITS-1){1'b0}}};
                  bit_cnt_r <= 4'h0;
               end
            SAC_SAMPLE:
               if (tick)
                  state_r <= SAC_DECIDE;
            SAC_DECIDE:
               if (tick)
               begin
                  // keep or drop the trial bit, then raise the next one
                  sar_r <= (sar_r & ~trial_bit) | (cmp_i ? trial_bit : '0)
                     | (trial_bit >> 1);
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (bit_cnt_r == `SAC_BIT_DECISIONS - 4'h1)
                     state_r <= SAC_FINISH;
               end
            SAC_FINISH:
               if (tick)
                  state_r <= SAC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         result_r <= '0;
      else if (done_evt)
         result_r <= sar_r;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         start_busy_r <= 1'b0;
      else if (done_evt)
         start_busy_r <= 1'b0;
      else if (start_req)
         start_busy_r <= 1'b1;
   end

   // divider field frozen while converting; start while busy ignored
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         div_sel_r <= 3'h0;
      else if (wr_ctrl && state_r == SAC_IDLE)
         div_sel_r <= pwdata_i[2:0];
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         refch_r <= `SAC_REFCH_RST;
      else if (wr_refch)
      begin
         // taken at once, even mid-conversion; software owns the settling time
         refch_r <= pwdata_i[7:0];
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_en_r <= 8'h00;
      else if (wr_irq_en)
         irq_en_r <= pwdata_i[7:0];
   end

   // done flag: set wins over the clear code
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         done_flag_r <= 1'b0;
      else if (done_evt)
         done_flag_r <= 1'b1;
      else if (wr_pend && pwdata_i[7:0] == `SAC_DONE_CLR_VAL)
         done_flag_r <= 1'b0;
   end

   // sticky status, write one to clear; set wins
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         stat_r <= 8'h00;
      else if (wr_stat)
         stat_r <= (stat_r & ~pwdata_i[7:0]) | {done_evt, 7'h00};
      else if (done_evt)
         stat_r[`SAC_DONE_BIT] <= 1'b1;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         mask_r <= 8'h00;
      else if (wr_mask)
         mask_r <= pwdata_i[7:0];
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_o <= 1'b0;
      else
      begin
         // both sources share the one level pin
         irq_o <= (done_flag_r & irq_en_r[`SAC_DONE_BIT]) | (|(stat_r & mask_r));
      end
   end

   // read mux; enable bit 6 is not implemented and reads 0
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (idx)
         {2'h0, `SAC_IDX_IRQ_EN}: rd_byte = {irq_en_r[7], 1'b0, irq_en_r[5:0]};
         {2'h0, `SAC_IDX_IRQ_PEND}: rd_byte = {done_flag_r, 7'h00};
         {2'h0, `SAC_IDX_RES_HI}: rd_byte = result_r[11:4];
         {2'h0, `SAC_IDX_CTRL}: rd_byte = {result_r[3:0], start_busy_r, div_sel_r};
         {2'h0, `SAC_IDX_REFCH}: rd_byte = refch_r;
         {2'h0, `SAC_IDX_IRQ_STAT}: rd_byte = stat_r;
         {2'h0, `SAC_IDX_IRQ_MASK}: rd_byte = mask_r;
         default: rd_byte = 8'h00;
      endcase
   end

   // zero-wait apb: setup registers ready and data for the access cycle
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end
      else
      begin
         pready_o <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~mapped;
         prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         dac_o <= '0;
         sample_o <= 1'b0;
         mux_sel_o <= 5'h1f;
         mux_valid_o <= 1'b0;
         ref_sel_o <= 2'h0;
         ref_low_o <= 1'b0;
      end
      else
      begin
         dac_o <= sar_r;
         sample_o <= state_r == SAC_SAMPLE;
         mux_sel_o <= refch_r[4:0];
         mux_valid_o <= chan_ok(refch_r[4:0]);
         ref_sel_o <= refch_r[7:6];
         ref_low_o <= refch_r[5] && refch_r[7:6] == 2'h0;
      end
   end
endmodule // sac_top

// ===== verif/sac_core_model.sv
// Purpose: comparator model of the analog core
// Assumes: input level held at the end of the sample phase
// Notes: answers in the same cycle as the trial code
`timescale 1ns/100ps
module sac_core_model (
   input wire logic clk_i,          // clock
   input wire logic [11:0] level_i, // analog input level
   input wire logic [11:0] dac_i,   // trial code
   input wire logic sample_i,       // sample phase
   output logic cmp_o               // input at or above trial
);
   logic [11:0] held_r;
   always_ff @(posedge clk_i)
   begin
      if (sample_i)
      begin
         held_r <= level_i;
      end
   end
   assign cmp_o = held_r >= dac_i;
endmodule // sac_core_model

// ===== verif/sac_monitor.sv
// Purpose: port checks of the converter control block
// Assumes: byte address is index times four
// Notes: bound into sac_top
`timescale 1ns/100ps
module sac_monitor #(
   parameter int RES_BITS = 12
)
(
   input wire logic clk_i,                 // w
   input wire logic sys_rst_i,             // w
   input wire logic psel_i,                // w
   input wire logic penable_i,             // w
   input wire logic pwrite_i,              // w
   input wire logic [11:0] paddr_i,        // w
   input wire logic [31:0] pwdata_i,       // w
   input wire logic [31:0] prdata_o,       // w
   input wire logic pready_o,              // w
   input wire logic pslverr_o,             // w
   input wire logic cmp_i,                 // w
   input wire logic [RES_BITS-1:0] dac_o,  // w
   input wire logic sample_o,              // w
   input wire logic [4:0] mux_sel_o,       // w
   input wire logic mux_valid_o,           // w
   input wire logic [1:0] ref_sel_o,       // w
   input wire logic ref_low_o,             // w
   input wire logic irq_o                  // w
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic wr_sel;
   logic [7:0] sel_r;
   assign wr_sel = pready_o && pwrite_i && paddr_i == 12'h064;
   always_ff @(posedge clk_i)
   begin
      if (wr_sel)
      begin
         sel_r <= pwdata_i[7:0];
      end
   end
   chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
      else $error("ready outside access");
   chk_ready_answer: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside access");
   chk_err_unmapped: assert property (pready_o && paddr_i == 12'h070 |-> pslverr_o)
      else $error("unmapped without error");
   chk_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   chk_select_follow: assert property (wr_sel |-> ##2 mux_sel_o == sel_r[4:0]
      && ref_sel_o == sel_r[7:6] && ref_low_o == (sel_r[7:5] == 3'h1))
      else $error("select outputs stale");
   chk_chan_valid: assert property (mux_valid_o == (mux_sel_o <= 5'h0c
      || mux_sel_o == 5'h0e || mux_sel_o == 5'h17))
      else $error("channel valid wrong");
   chk_low_ref: assert property (ref_low_o |-> ref_sel_o == 2'h0)
      else $error("low reference with other field");
   cover property (wr_sel);
   cover property ($fell(sample_o));
   cover property ($rose(irq_o));
endmodule // sac_monitor
bind sac_top sac_monitor #(.RES_BITS(RES_BITS)) mon_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .cmp_i(cmp_i), .dac_o(dac_o), .sample_o(sample_o), .mux_sel_o(mux_sel_o),
   .mux_valid_o(mux_valid_o), .ref_sel_o(ref_sel_o), .ref_low_o(ref_low_o), .irq_o(irq_o));

// ===== verif/sac_top_test.sv
// Purpose: self-checking bench of the converter control block
// Assumes: zero wait state apb slave
// Notes: dividers 0 to 2 only
`timescale 1ns/100ps
module sac_top_test;
   logic clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, cmp;
   logic pready, pslverr, sample, mvalid, rlow, irq, er;
   logic [11:0] paddr = 0, lvl = 0, dac;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [4:0] msel;
   logic [1:0] rsel;
   int n_errors = 0, samples_checked = 0, cyc = 0;
   localparam logic [7:0] RT [6] = '{8'h0c, 8'h2d, 8'h4e, 8'h97, 8'h38, 8'hf7};
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   sac_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .cmp_i(cmp), .dac_o(dac), .sample_o(sample),
      .mux_sel_o(msel), .mux_valid_o(mvalid), .ref_sel_o(rsel), .ref_low_o(rlow), .irq_o(irq));
   sac_core_model core_u (.clk_i(clk_i), .level_i(lvl), .dac_i(dac), .sample_i(sample),
      .cmp_o(cmp));
   task give_verdict;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_i);
      penable <= 1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk_i);
         if (pready === 1'b1)
            break;
      end
      if (k == 20)
      begin
         n_errors++;
         give_verdict;
      end
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task conv(input logic [2:0] d, input logic [11:0] v, input bit busy_wr);
      int t0, k, p;
      p = 1 << (8 - d);
      lvl <= v;
      apb(1, 12'h060, {28'h0, 1'b1, d});
      t0 = cyc;
      apb(0, 12'h060, 0);
      chk("busy", rd[3], 1);
      chk("trial", {sample, dac}, {1'b1, 12'h800});
      if (busy_wr)
         apb(1, 12'h060, 32'h0a);
      for (k = 0; k < 2000; k++)
      begin
         apb(0, 12'h060, 0);
         if (rd[3] === 1'b0)
            break;
      end
      if (k == 2000)
      begin
         n_errors++;
         give_verdict;
      end
      chk("time", cyc - t0 >= 14 * p + 1 && cyc - t0 <= 14 * p + 5, 1);
      apb(0, 12'h05c, 0);
      chk("res_hi", rd, {24'h0, v[11:4]});
      chk("trial_end", dac, v);
      apb(0, 12'h060, 0);
      chk("res_lo", rd, {24'h0, v[3:0], 1'b0, d});
   endtask
   task t_reset;
      chk("pins_rst", {msel, mvalid, rsel, rlow, irq, sample, dac}, {5'h1f, 18'h0});
      apb(0, 12'h064, 0);
      chk("refch_rst", rd, 32'h1f);
      apb(0, 12'h060, 0);
      chk("ctrl_rst", rd, 0);
      apb(0, 12'h030, 0);
      chk("pend_rst", rd, 0);
      apb(0, 12'h070, 0);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
   endtask
   task t_rst_mid;
      apb(1, 12'h060, 32'h08);
      sys_rst_i <= 1;
      @(posedge clk_i);
      sys_rst_i <= 0;
      chk("rst_pins", {sample, irq, msel}, {2'b00, 5'h1f});
      apb(0, 12'h060, 0);
      chk("rst_busy", rd, 0);
   endtask
   task t_route;
      logic [4:0] ch;
      for (int i = 0; i < 6; i++)
      begin
         ch = RT[i][4:0];
         apb(1, 12'h064, {24'h0, RT[i]});
         apb(0, 12'h064, 0);
         chk("refch", rd, {24'h0, RT[i]});
         chk("chan", {msel, mvalid}, {ch, ch <= 5'h0c || ch == 5'h0e || ch == 5'h17});
         chk("ref", {rsel, rlow}, {RT[i][7:6], RT[i][7:5] == 3'h1});
      end
   endtask
   task t_irq;
      apb(1, 12'h064, 32'h02);
      conv(0, 12'ha5c, 0);
      apb(0, 12'h030, 0);
      chk("flag", {irq, rd[7]}, 2'b01);
      apb(1, 12'h02c, 32'hc0);
      apb(0, 12'h02c, 0);
      chk("en", {irq, rd[30:0]}, {1'b1, 31'h80});
      apb(1, 12'h030, 32'hff);
      apb(0, 12'h030, 0);
      chk("keep", rd[7], 1);
      apb(1, 12'h030, 32'h7f);
      apb(0, 12'h030, 0);
      chk("clr", {irq, rd[7]}, 0);
      apb(1, 12'h02c, 0);
   endtask
   task t_stat;
      conv(1, 12'h3a1, 1);
      conv(2, 12'hfff, 0);
      apb(0, 12'h068, 0);
      chk("stat", {irq, rd[7]}, 2'b01);
      apb(1, 12'h030, 32'h7f);
      apb(1, 12'h06c, 32'h80);
      apb(0, 12'h06c, 0);
      chk("mask", irq, 1);
      apb(1, 12'h068, 32'h80);
      apb(0, 12'h068, 0);
      chk("stat_clr", {irq, rd[30:0]}, 0);
   endtask
   initial
   begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 0;
      t_reset;
      t_route;
      t_irq;
      t_stat;
      t_rst_mid;
      give_verdict;
   end
endmodule // sac_top_test
